// file: bench/srh_host_asserts.sv
// Pin protocol checks for the RAM host
`timescale 1ns/1ps
`default_nettype none
module srh_host_asserts (
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire srh_pkg::srh_pins_s pins_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_we_in_sel: assert property (!pins_o.we_n |-> !pins_o.sel_n)
    else $error("strobe outside select");
  a_addr_setup: assert property ($fell(pins_o.we_n) |->
    $past(pins_o.word_addr, 3) == pins_o.word_addr) else $error("setup");
  a_we_width: assert property ($fell(pins_o.we_n) |->
    !pins_o.we_n [*3]) else $error("strobe short");
  a_addr_hold: assert property ($rose(pins_o.we_n) |=>
    $stable(pins_o.word_addr) [*2]) else $error("hold");
  cover property ($fell(pins_o.we_n));
  cover property ($rose(pins_o.sel_n));
  cover property (!pins_o.sel_n && pins_o.we_n);
endmodule : srh_host_asserts
bind srh_host srh_host_asserts u_srh_host_asserts (.clock_i(clock_i),
  .rst_i(rst_i), .pins_o(pins_o));
`default_nettype wire

// file: bench/srh_ram_model.sv
// Behavioural inverting 16x4 RAM, open-collector outputs
`timescale 1ns/1ps
`default_nettype none
module srh_ram_model (
  input  wire srh_pkg::srh_pins_s pins_i,
  output wire logic [3:0]         data_out_n_o
);
  logic [3:0] mem [16];
  always @* if (!pins_i.sel_n && !pins_i.we_n)
    mem[pins_i.word_addr] = pins_i.data_in;
  // Pull-up when off; no lag after a write
  // Open-collector build only; the driven build is not modelled
  assign data_out_n_o = (!pins_i.sel_n && pins_i.we_n) ?
    ~mem[pins_i.word_addr] : 4'hF;
endmodule : srh_ram_model
`default_nettype wire

// file: bench/tb_scratchpad_ram_16x4.sv
// Bench for the scratch-pad RAM host
`timescale 1ns/1ps
`default_nettype none
module tb_scratchpad_ram_16x4;
  import srh_pkg::*;
  logic       clock_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
  srh_req_s   req_i = '0;
  logic       req_ready_o, rd_valid_o, wr_done_o;
  logic [3:0] rd_data_o;
  wire  [3:0] data_out_n_i;
  srh_pins_s  pins_o;
  int         bad_count = 0, tests_run = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  srh_host u_srh_host (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_done_o(wr_done_o),
    .data_out_n_i(data_out_n_i), .pins_o(pins_o));
  srh_ram_model u_srh_ram_model (.pins_i(pins_o),
    .data_out_n_o(data_out_n_i));
  task automatic check(input string what, input logic [3:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [3:0] a, d);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{w, a, d};
    // Ready is looked at between edges, the take is the next edge
    do @(negedge clock_i); while (req_ready_o !== 1'b1);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    do @(negedge clock_i); while (rd_valid_o !== 1'b1 && wr_done_o !== 1'b1);
    check("kind", {2'b00, wr_done_o, rd_valid_o}, w ? 4'h2 : 4'h1);
  endtask : xfer
  task automatic t_fill;
    for (int i = 0; i < 16; i++) xfer(1'b1, 4'(i), 4'(i) ^ 4'h5);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, 4'(i), 4'h0);
      check("word", rd_data_o, 4'(i) ^ 4'h5);
    end
    $display("t_fill done");
  endtask : t_fill
  task automatic t_rewrite;
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 4'hF, {4{k[0]}});
      xfer(1'b0, 4'hF, 4'h0);
      check("rewrite", rd_data_o, {4{k[0]}});
      check("idle", data_out_n_i, 4'hF);
    end
    $display("t_rewrite done");
  endtask : t_rewrite
  task automatic final_report;
    $display("tests %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 1500) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    t_fill();
    t_rewrite();
    final_report();
  end
endmodule : tb_scratchpad_ram_16x4
`default_nettype wire

// file: core/srh_host.sv
// Host controller driving a 16x4 inverting scratch-pad RAM
//
// Overview of operation
// - Address first, strobe after setup, hold
// - Address and data lines go out unpermuted
// - Address bits are driven true, not inverted
`timescale 1ns/1ps
`default_nettype none
`include "srh_params.svh"
module srh_host #(
  parameter int unsigned SETUP_CYC  = `SRH_SETUP_CYC,
  parameter int unsigned HOLD_CYC   = `SRH_HOLD_CYC,
  parameter int unsigned PULSE_CYC  = `SRH_PULSE_CYC,
  parameter int unsigned ACCESS_CYC = `SRH_ACCESS_CYC
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      req_valid_i,
  input  wire srh_pkg::srh_req_s         req_i,
  output var  logic                      req_ready_o,
  output var  logic                      rd_valid_o,
  output var  logic [`SRH_DATA_W-1:0]    rd_data_o,
  output var  logic                      wr_done_o,
  input  wire logic [`SRH_DATA_W-1:0]    data_out_n_i,
  output var  srh_pkg::srh_pins_s        pins_o
);
  import srh_pkg::*;

  srh_state_e               state_q, state_d;
  logic [`SRH_CNT_W-1:0]    cnt_q, cnt_d;
  srh_pins_s                pins_q, pins_d;
  logic                     rd_valid_q, rd_valid_d;
  logic [`SRH_DATA_W-1:0]   rd_data_q, rd_data_d;
  logic                     wr_done_q, wr_done_d;
  logic                     req_ready_q, req_ready_d;

  // Write walk with default counts, edges counted from the take:
  //   take      address, data and select change together
  //   +3 edges  strobe falls, address has stood three cycles
  //   +6 edges  strobe rises, data stood for the whole pulse
  //   +9 edges  select rises and the done pulse goes out
  // Read walk with default counts:
  //   take      address and select change together
  //   +3 edges  access time spent, sample on the next edge
  //   +4 edges  word captured, select rises, valid pulse
  // The counter restarts at one in each timed state, so a
  // count of N keeps that state for exactly N cycles.
  // Counts above seven wrap the three-bit counter; keep
  // every timing count between one and seven.

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    pins_d     = pins_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    wr_done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // Deselected between accesses so shared outputs stay free
        pins_d.sel_n = 1'b1;
        pins_d.we_n  = 1'b1;
        // Ready gates the take: no request is seen in the reset
        // cycle, where ready is still low
        if (req_valid_i && req_ready_q) begin
          // Address settles before the write strobe moves; select falls with it
          // Address and data go out true and unpermuted; the same
          // mapping serves reads and writes
          pins_d.word_addr = req_i.addr;
          pins_d.data_in   = req_i.data;
          pins_d.sel_n     = 1'b0;
          cnt_d            = `SRH_CNT_W'(1);
          state_d = req_i.write ? ST_WR_SETUP : ST_RD_ACCESS;
        end
      end
      ST_WR_SETUP: begin
        cnt_d = cnt_q + `SRH_CNT_W'(1);
        if (cnt_q >= `SRH_CNT_W'(SETUP_CYC)) begin
          pins_d.we_n = 1'b0;
          cnt_d       = `SRH_CNT_W'(1);
          state_d     = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        cnt_d = cnt_q + `SRH_CNT_W'(1);
        if (cnt_q >= `SRH_CNT_W'(PULSE_CYC)) begin
          pins_d.we_n = 1'b1;
          cnt_d       = `SRH_CNT_W'(1);
          state_d     = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // Address and select held after strobe rises
        cnt_d = cnt_q + `SRH_CNT_W'(1);
        if (cnt_q >= `SRH_CNT_W'(HOLD_CYC)) begin
          pins_d.sel_n = 1'b1;
          wr_done_d    = 1'b1;
          state_d      = ST_IDLE;
        end
      end
      ST_RD_ACCESS: begin
        cnt_d = cnt_q + `SRH_CNT_W'(1);
        if (cnt_q >= `SRH_CNT_W'(ACCESS_CYC)) begin
          state_d = ST_RD_DONE;
        end
      end
      ST_RD_DONE: begin
        // Outputs are inverting, so undo it here
        rd_data_d    = ~data_out_n_i;
        rd_valid_d   = 1'b1;
        pins_d.sel_n = 1'b1;
        state_d      = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Ready registers the next state, so it mirrors the idle state in the same cycle
    req_ready_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q          <= ST_IDLE;
      cnt_q            <= '0;
      pins_q.sel_n     <= 1'b1;
      pins_q.we_n      <= 1'b1;
      pins_q.word_addr <= '0;
      pins_q.data_in   <= '0;
      rd_valid_q       <= 1'b0;
      rd_data_q        <= '0;
      wr_done_q        <= 1'b0;
      req_ready_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      pins_q     <= pins_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
      wr_done_q  <= wr_done_d;
      req_ready_q <= req_ready_d;
    end
  end

  assign req_ready_o = req_ready_q;
  assign rd_valid_o  = rd_valid_q;
  assign rd_data_o   = rd_data_q;
  assign wr_done_o   = wr_done_q;
  assign pins_o      = pins_q;
endmodule : srh_host
`default_nettype wire

// file: core/srh_params.svh
// Constants for the scratch-pad RAM host controller
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH
`define SRH_CLK_PERIOD_NS   10
`define SRH_ADDR_SETUP_NS   25
`define SRH_ADDR_HOLD_NS    25
`define SRH_WE_PULSE_NS     25
`define SRH_READ_ACCESS_NS  30
`define SRH_SETUP_CYC  ((`SRH_ADDR_SETUP_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_HOLD_CYC   ((`SRH_ADDR_HOLD_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_PULSE_CYC  ((`SRH_WE_PULSE_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_ACCESS_CYC ((`SRH_READ_ACCESS_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_CNT_W      3
`define SRH_ADDR_W     4
`define SRH_DATA_W     4
`endif

// file: core/srh_pkg.sv
// Types for the scratch-pad RAM host controller
`include "srh_params.svh"
package srh_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RD_ACCESS,
    ST_RD_DONE
  } srh_state_e;

  typedef struct packed {
    logic                     write;
    logic [`SRH_ADDR_W-1:0]   addr;
    logic [`SRH_DATA_W-1:0]   data;
  } srh_req_s;

  typedef struct packed {
    logic                     sel_n;
    logic                     we_n;
    logic [`SRH_ADDR_W-1:0]   word_addr;
    logic [`SRH_DATA_W-1:0]   data_in;
  } srh_pins_s;
endpackage : srh_pkg
